//--- core/ocs_top.v
// Relay output selection and overtorque detection with APB registers
`timescale 1ns/100ps
`default_nettype none
`include "ocs_map.vh"

module ocs_top #(
    parameter TICK_CYCLES = `OCS_TICK_NS / `OCS_CLK_NS,
    parameter TICK_W = 24
) (
    // Clock and reset
    input wire CLK,
    input wire RST,
    // APB slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    // Drive state, same clock domain
    input wire DRIVE_FAULT,
    input wire PROCESSOR_FAULT_A,
    input wire PROCESSOR_FAULT_B,
    input wire DRIVE_RUNNING,
    input wire DRIVE_READY,
    input wire BASE_BLOCK,
    input wire REF_FROM_KEYPAD,
    input wire AUTO_RESTART,
    input wire SERIAL_COMMAND,
    input wire MOTOR_OVERLOAD,
    input wire [7:0] DRIVE_OVERLOAD_PCT,
    input wire FREF_MISSING,
    input wire [7:0] HEATSINK_DEG_C,
    input wire [7:0] FEEDBACK_PCT,
    input wire STOPPING,
    input wire DC_BRAKING,
    input wire [15:0] OUT_FREQ,
    input wire [15:0] FREQ_REF,
    input wire [7:0] OUT_CURRENT_PCT,
    // External timer terminal, asynchronous
    input wire TIMER_IN,
    // Contact drives, high = closed
    output wire RELAY1_CLOSED,
    output wire RELAY2_CLOSED,
    // Overtorque results
    output reg OVERTORQUE_INDICATION,
    output reg OVERTORQUE_ALARM,
    output reg COAST_STOP
);

    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    reg [31:0] sel_ff; // Both selectors
    reg [31:0] freq_ff; // Level and agreement width
    reg [31:0] otq_ff; // Mode, level, time
    reg [31:0] timer_ff; // Timer delays, feedback loss
    reg ot_fault_ff; // Latched overtorque fault
    reg [TICK_W-1:0] tick_cnt_ff; // 0.1 s prescaler
    reg tick_ff; // One cycle per 0.1 s
    reg [11:0] ot_cnt_ff; // Overtorque qualify time
    reg ot_det_ff; // Overtorque detected
    reg tin_meta_ff; // Timer input sync stage 1
    reg tin_sync_ff; // Timer input sync stage 2
    reg [7:0] ton_cnt_ff; // Closed time of timer input
    reg [7:0] toff_cnt_ff; // Open time of timer input
    reg timer_out_ff; // Timer function result
    reg [7:0] fb_cnt_ff; // Feedback-low time
    reg fb_loss_ff; // Feedback loss detected
    reg [1:0] relay_ff; // Contact states
    reg [1:0] nxt_relay; // Next contact states

    // Register fields
    wire [15:0] det_level = freq_ff[15:0]; // 0.01 Hz units
    wire [15:0] agree_width = freq_ff[31:16]; // 0.01 Hz units
    wire [2:0] ot_mode = otq_ff[2:0];
    wire [7:0] ot_level = otq_ff[15:8]; // Percent of rated
    wire [11:0] ot_time = otq_ff[27:16]; // 0.1 s units
    wire [7:0] ton_delay = timer_ff[7:0];
    wire [7:0] toff_delay = timer_ff[15:8];
    wire [7:0] fb_level = timer_ff[23:16];
    wire [7:0] fb_delay = timer_ff[31:24];

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    wire setup = PSEL & ~PENABLE;
    wire wr_en = PSEL & PENABLE & PWRITE;
    wire mapped = (PADDR == `OCS_REG_SELECT) | (PADDR == `OCS_REG_FREQ) |
        (PADDR == `OCS_REG_OTQ) | (PADDR == `OCS_REG_TIMER) |
        (PADDR == `OCS_REG_STATUS);
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;

    // Status word seen by software
    wire [31:0] status_w = {24'h000000, relay_ff, fb_loss_ff, timer_out_ff,
        OVERTORQUE_ALARM, ot_det_ff, 1'b0, ot_fault_ff};

    // Read data latched in setup so it comes from flops
    always @(posedge CLK) begin
        if (RST) begin
            PRDATA <= 32'h00000000;
        end else if (setup & ~PWRITE) begin
            case (PADDR)
                `OCS_REG_SELECT: PRDATA <= sel_ff;
                `OCS_REG_FREQ: PRDATA <= freq_ff;
                `OCS_REG_OTQ: PRDATA <= otq_ff;
                `OCS_REG_TIMER: PRDATA <= timer_ff;
                `OCS_REG_STATUS: PRDATA <= status_w;
                default: PRDATA <= 32'h00000000; // Unmapped reads zero
            endcase
        end
    end

    // Settings writes; unused selector bits stay zero
    always @(posedge CLK) begin
        if (RST) begin
            sel_ff <= `OCS_SEL_RST;
            freq_ff <= `OCS_FREQ_RST;
            otq_ff <= `OCS_OTQ_RST;
            timer_ff <= `OCS_TIMER_RST;
        end else if (wr_en) begin
            case (PADDR)
                `OCS_REG_SELECT: sel_ff <= PWDATA & 32'h00001F1F;
                `OCS_REG_FREQ: freq_ff <= PWDATA;
                `OCS_REG_OTQ: otq_ff <= PWDATA & 32'h0FFFFF07;
                `OCS_REG_TIMER: timer_ff <= PWDATA;
                default: sel_ff <= sel_ff; // Others hold
            endcase
        end
    end

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    // Prescaler giving one pulse every 0.1 s
    always @(posedge CLK) begin
        if (RST) begin
            tick_cnt_ff <= {TICK_W{1'b0}};
            tick_ff <= 1'b0;
        end else if (tick_cnt_ff == TICK_CYCLES[TICK_W-1:0] - 1'b1) begin
            tick_cnt_ff <= {TICK_W{1'b0}};
            tick_ff <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Frequency comparisons
    // ----------------------------------------
    // Absolute differences, shared by both outputs
    wire [15:0] d_ref = (OUT_FREQ >= FREQ_REF) ? OUT_FREQ - FREQ_REF :
        FREQ_REF - OUT_FREQ;
    wire [15:0] d_lvl = (OUT_FREQ >= det_level) ? OUT_FREQ - det_level :
        det_level - OUT_FREQ;
    wire at_speed = d_ref <= agree_width;
    wire coincide = at_speed & (d_lvl <= agree_width);
    wire f_low = OUT_FREQ <= det_level;
    wire f_high = OUT_FREQ >= det_level;

    // ----------------------------------------
    // Overtorque detection
    // ----------------------------------------
    // Odd modes only at set frequency, even modes unless stopping or DC braking
    wire ot_window = ot_mode[0] ? at_speed : ~STOPPING & ~DC_BRAKING;
    wire ot_enable = (ot_mode != `OCS_OTQ_OFF) & (ot_mode <= 3'h4);
    wire ot_cond = ot_enable & ot_window &
        (OUT_CURRENT_PCT >= ot_level);
    wire ot_coast = (ot_mode == 3'h3) | (ot_mode == 3'h4);
    wire st_clear = wr_en & (PADDR == `OCS_REG_STATUS) &
        PWDATA[`OCS_ST_OTQ_FAULT];

    // Qualifying timer, restarted whenever the condition drops
    always @(posedge CLK) begin
        if (RST) begin
            ot_cnt_ff <= 12'h000;
            ot_det_ff <= 1'b0;
        end else if (!ot_cond) begin
            ot_cnt_ff <= 12'h000;
            ot_det_ff <= 1'b0;
        end else begin
            if (tick_ff && ot_cnt_ff < ot_time) begin
                ot_cnt_ff <= ot_cnt_ff + 12'h001;
            end
            ot_det_ff <= ot_cnt_ff >= ot_time;
        end
    end

    // Alarm or latched fault with coast stop; a new detect beats clear
    always @(posedge CLK) begin
        if (RST) begin
            ot_fault_ff <= 1'b0;
            OVERTORQUE_INDICATION <= 1'b0;
            OVERTORQUE_ALARM <= 1'b0;
            COAST_STOP <= 1'b0;
        end else begin
            if (ot_det_ff & ot_coast) begin
                ot_fault_ff <= 1'b1;
            end else if (st_clear) begin
                ot_fault_ff <= 1'b0;
            end
            OVERTORQUE_ALARM <= ot_det_ff & ~ot_coast;
            OVERTORQUE_INDICATION <= ot_det_ff | ot_fault_ff;
            COAST_STOP <= ot_fault_ff;
        end
    end

    // ----------------------------------------
    // Timer function input
    // ----------------------------------------
    // Two-stage synchroniser for the terminal
    always @(posedge CLK) begin
        if (RST) begin
            tin_meta_ff <= 1'b0;
            tin_sync_ff <= 1'b0;
        end else begin
            tin_meta_ff <= TIMER_IN;
            tin_sync_ff <= tin_meta_ff;
        end
    end

    // On and off delays counted in 0.1 s steps
    always @(posedge CLK) begin
        if (RST) begin
            ton_cnt_ff <= 8'h00;
            toff_cnt_ff <= 8'h00;
            timer_out_ff <= 1'b0;
        end else if (tin_sync_ff) begin
            toff_cnt_ff <= 8'h00;
            if (tick_ff && ton_cnt_ff < ton_delay) begin
                ton_cnt_ff <= ton_cnt_ff + 8'h01;
            end
            if (ton_cnt_ff >= ton_delay) begin
                timer_out_ff <= 1'b1;
            end
        end else begin
            ton_cnt_ff <= 8'h00;
            if (tick_ff && toff_cnt_ff < toff_delay) begin
                toff_cnt_ff <= toff_cnt_ff + 8'h01;
            end
            if (toff_cnt_ff >= toff_delay) begin
                timer_out_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Feedback loss
    // ----------------------------------------
    // Feedback below level must last longer than the delay
    always @(posedge CLK) begin
        if (RST) begin
            fb_cnt_ff <= 8'h00;
            fb_loss_ff <= 1'b0;
        end else if (FEEDBACK_PCT >= fb_level) begin
            fb_cnt_ff <= 8'h00;
            fb_loss_ff <= 1'b0;
        end else begin
            if (tick_ff && fb_cnt_ff <= fb_delay) begin
                fb_cnt_ff <= fb_cnt_ff + 8'h01;
            end
            fb_loss_ff <= fb_cnt_ff > fb_delay;
        end
    end

    // ----------------------------------------
    // Shared warnings
    // ----------------------------------------
    wire ol_warn = MOTOR_OVERLOAD |
        (DRIVE_OVERLOAD_PCT >= `OCS_DRIVE_OL_PCT);
    wire oh_warn = HEATSINK_DEG_C >= `OCS_OH_DEG_C;
    wire any_fault = DRIVE_FAULT | PROCESSOR_FAULT_A | PROCESSOR_FAULT_B;

    // ----------------------------------------
    // Contact selection, one per output
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_relay
            wire [4:0] sel = sel_ff[g*`OCS_SEL_STRIDE +: 5];
            // Condition picked by this output's selector
            always @* begin
                case (sel)
                    `OCS_C_FAULT: nxt_relay[g] = DRIVE_FAULT;
                    `OCS_C_RUN: nxt_relay[g] = DRIVE_RUNNING;
                    `OCS_C_AGREE: nxt_relay[g] = at_speed;
                    `OCS_C_COINC: nxt_relay[g] = coincide;
                    `OCS_C_FLOW: nxt_relay[g] = f_low;
                    `OCS_C_FHIGH: nxt_relay[g] = f_high;
                    `OCS_C_OTQ_NO: nxt_relay[g] = ot_det_ff;
                    `OCS_C_OTQ_NC: nxt_relay[g] = ~ot_det_ff;
                    `OCS_C_COAST: nxt_relay[g] = BASE_BLOCK;
                    `OCS_C_KEYPAD: nxt_relay[g] = REF_FROM_KEYPAD;
                    `OCS_C_READY: nxt_relay[g] = DRIVE_READY &
                        ~any_fault;
                    `OCS_C_TIMER: nxt_relay[g] = timer_out_ff;
                    `OCS_C_RESTART: nxt_relay[g] = AUTO_RESTART;
                    `OCS_C_OLWARN: nxt_relay[g] = ol_warn;
                    `OCS_C_REFMISS: nxt_relay[g] = FREF_MISSING;
                    `OCS_C_SERIAL: nxt_relay[g] = SERIAL_COMMAND;
                    `OCS_C_FBLOSS: nxt_relay[g] = fb_loss_ff;
                    `OCS_C_OHWARN: nxt_relay[g] = oh_warn;
                    default: nxt_relay[g] = 1'b0; // Unused codes open
                endcase
            end
        end
    endgenerate

    // Contacts refreshed every cycle
    always @(posedge CLK) begin
        if (RST) begin
            relay_ff <= 2'b00;
        end else begin
            relay_ff <= nxt_relay;
        end
    end

    assign RELAY1_CLOSED = relay_ff[0];
    assign RELAY2_CLOSED = relay_ff[1];

endmodule // ocs_top
`default_nettype wire

//--- core/ocs_map.vh
// Constants for the relay output selection and overtorque block
//
// Contract
// - Two relays, each with selector codes 0-17
// - Code 0 closes on fault, not processor faults
// - Code 1 running; code 10 ready, unfaulted
// - Code 2 closes when frequency agrees with reference
// - Code 3 agrees with reference and detection level
// - Code 4 closes when frequency at/below level
// - Code 5 closes when frequency at/above level
// - Code 6 closes, code 7 opens on overtorque
// - Code 8 closes while output blocked, coasting
// - Code 9 closed for keypad, open for external
// - Code 12 auto-restart; code 15 serial commands
// - Code 13 motor or drive overload warning
// - Code 14 reference missing; 16 feedback loss
// - Code 17 closes when heatsink at 90 C
// - Detection level 0.0-400.0 Hz, default 0.0
// - Agreement width default 2.0 Hz, max 25.50
// - Overtorque when current at/above level
// - Mode 0 off; 1,3 at speed; 2,4 always; code blocks 2,4 while stopping or DC braking
// - Modes 1,2 alarm only; 3,4 coast stop
// - Overtorque level default 160%, range 30-200%
// - Overtorque must persist detection time, default 0.1s
// - Code 11 timer with on and off delays
`ifndef OCS_MAP_VH
`define OCS_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OCS_REG_SELECT 8'h00
`define OCS_REG_FREQ 8'h04
`define OCS_REG_OTQ 8'h08
`define OCS_REG_TIMER 8'h0C
`define OCS_REG_STATUS 8'h10

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define OCS_SEL_STRIDE 8
`define OCS_SEL_RST 32'h00000000
`define OCS_FREQ_RST 32'h00C80000
`define OCS_OTQ_RST 32'h0001A000
`define OCS_TIMER_RST 32'h0A000000
`define OCS_ST_OTQ_FAULT 0

// ----------------------------------------
// Selector codes
// ----------------------------------------
`define OCS_C_FAULT 5'h00
`define OCS_C_RUN 5'h01
`define OCS_C_AGREE 5'h02
`define OCS_C_COINC 5'h03
`define OCS_C_FLOW 5'h04
`define OCS_C_FHIGH 5'h05
`define OCS_C_OTQ_NO 5'h06
`define OCS_C_OTQ_NC 5'h07
`define OCS_C_COAST 5'h08
`define OCS_C_KEYPAD 5'h09
`define OCS_C_READY 5'h0A
`define OCS_C_TIMER 5'h0B
`define OCS_C_RESTART 5'h0C
`define OCS_C_OLWARN 5'h0D
`define OCS_C_REFMISS 5'h0E
`define OCS_C_SERIAL 5'h0F
`define OCS_C_FBLOSS 5'h10
`define OCS_C_OHWARN 5'h11

// ----------------------------------------
// Thresholds and time base
// ----------------------------------------
`define OCS_OTQ_OFF 3'h0
`define OCS_DRIVE_OL_PCT 8'h50
`define OCS_OH_DEG_C 8'h5A
`define OCS_TICK_NS 100000000
`define OCS_CLK_NS 100

`endif

//--- verif/ocs_properties.sv
// Port checker for the relay selection and overtorque block
`timescale 1ns/100ps
`default_nettype none
module ocs_properties #(
    parameter TICK_CYCLES = 10,
    parameter TICK_W = 24
) (
    // Clock, reset and bus
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Results
    input wire logic RELAY1_CLOSED,
    input wire logic RELAY2_CLOSED,
    input wire logic OVERTORQUE_INDICATION,
    input wire logic OVERTORQUE_ALARM,
    input wire logic COAST_STOP
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    pready_high_a: assert property (PREADY)
        else $error("ready low");
    slverr_idle_a: assert property (!PENABLE |-> !PSLVERR)
        else $error("error outside access");
    slverr_unmapped_a: assert property (PSEL && PENABLE && PADDR > 8'h10
        |-> PSLVERR) else $error("unmapped access not flagged");
    slverr_mapped_a: assert property (PSEL && PENABLE && PADDR <= 8'h10
        && PADDR[1:0] == 2'h0 |-> !PSLVERR) else $error("mapped flagged");
    unmapped_zero_a: assert property (PSEL && !PENABLE && !PWRITE
        && PADDR > 8'h10 |=> PRDATA == 32'h0) else $error("unmapped data");
    prdata_hold_a: assert property (!(PSEL && !PENABLE && !PWRITE)
        |=> $stable(PRDATA)) else $error("read data moved");
    alarm_needs_det_a: assert property (OVERTORQUE_ALARM
        |-> OVERTORQUE_INDICATION) else $error("alarm without detect");
    coast_needs_det_a: assert property (COAST_STOP
        |-> OVERTORQUE_INDICATION) else $error("coast without detect");
    reset_clear_a: assert property (disable iff (1'b0) RST |=>
        !RELAY1_CLOSED && !RELAY2_CLOSED && !OVERTORQUE_INDICATION
        && !COAST_STOP && PRDATA == 32'h0) else $error("reset values");
endmodule // ocs_properties
bind ocs_top ocs_properties #(.TICK_CYCLES(TICK_CYCLES), .TICK_W(TICK_W))
    u_ocs_properties (.CLK(CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RELAY1_CLOSED(RELAY1_CLOSED),
    .RELAY2_CLOSED(RELAY2_CLOSED),
    .OVERTORQUE_INDICATION(OVERTORQUE_INDICATION),
    .OVERTORQUE_ALARM(OVERTORQUE_ALARM), .COAST_STOP(COAST_STOP));
`default_nettype wire

//--- verif/ocs_machine_side.sv
// Machine wiring model reading the two relay contacts
`timescale 1ns/100ps
`default_nettype none
module ocs_machine_side (
    // Contact drives from the block
    input wire logic relay1_closed,
    input wire logic relay2_closed,
    // Contact levels seen by the machine
    output logic relay1_normally_open_pin,
    output logic relay1_normally_closed_pin,
    output logic relay2_pin_a
);
    // Changeover contact: both throws, never together
    assign relay1_normally_open_pin = relay1_closed;
    assign relay1_normally_closed_pin = !relay1_closed;
    // Single normally open contact
    assign relay2_pin_a = relay2_closed;
endmodule // ocs_machine_side
`default_nettype wire

//--- verif/output_contact_select_overtorque_bench.sv
// Self-checking bench for the relay selection and overtorque block
`timescale 1ns/100ps
`default_nettype none
`include "ocs_map.vh"
module output_contact_select_overtorque_bench;
    // ----------------------------------------
    // Stimulus and observation
    // ----------------------------------------
    logic clk, rst, psel, pen, pwr, dflt, pfa, pfb, run, rdy, bb, kp, ars;
    logic ser, mol, fmiss, stp, dcb, tin;
    logic [7:0] paddr, dol, hs, fb, cur;
    logic [15:0] ofreq, fref;
    logic [31:0] pwdata;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, R1, R2, OTI, OTA, CST, NO1, NC1, P2;
    int err_total = 0;
    int checks_done = 0;
    ocs_top #(.TICK_CYCLES(10)) u_ocs_top (.CLK(clk), .RST(rst),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .DRIVE_FAULT(dflt), .PROCESSOR_FAULT_A(pfa),
        .PROCESSOR_FAULT_B(pfb), .DRIVE_RUNNING(run), .DRIVE_READY(rdy),
        .BASE_BLOCK(bb), .REF_FROM_KEYPAD(kp), .AUTO_RESTART(ars),
        .SERIAL_COMMAND(ser), .MOTOR_OVERLOAD(mol),
        .DRIVE_OVERLOAD_PCT(dol), .FREF_MISSING(fmiss),
        .HEATSINK_DEG_C(hs), .FEEDBACK_PCT(fb), .STOPPING(stp),
        .DC_BRAKING(dcb), .OUT_FREQ(ofreq), .FREQ_REF(fref),
        .OUT_CURRENT_PCT(cur), .TIMER_IN(tin), .RELAY1_CLOSED(R1),
        .RELAY2_CLOSED(R2), .OVERTORQUE_INDICATION(OTI),
        .OVERTORQUE_ALARM(OTA), .COAST_STOP(CST));
    ocs_machine_side u_ocs_machine_side (.relay1_closed(R1),
        .relay2_closed(R2), .relay1_normally_open_pin(NO1),
        .relay1_normally_closed_pin(NC1), .relay2_pin_a(P2));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask
    // One APB transfer, released once ready is seen or after 20 cycles without it
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (PREADY !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n >= 20) begin
            err_total++;
        end
        rd = PRDATA;
        er = PSLVERR;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
        chk(e, xe);
    endtask
    task sel(input logic [4:0] c1, input logic [4:0] c2);
        wr(`OCS_REG_SELECT, {19'h0, c2, 3'h0, c1});
    endtask
    task otq(input logic [2:0] m);
        wr(`OCS_REG_OTQ, {4'h0, 12'h003, 8'h64, 5'h0, m});
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        rdchk(`OCS_REG_SELECT, `OCS_SEL_RST, 1'b0);
        rdchk(`OCS_REG_FREQ, `OCS_FREQ_RST, 1'b0);
        rdchk(`OCS_REG_OTQ, `OCS_OTQ_RST, 1'b0);
        rdchk(`OCS_REG_TIMER, `OCS_TIMER_RST, 1'b0);
        rdchk(8'h20, 32'h0, 1'b1);
        pfa <= 1'b1;
        pfb <= 1'b1;
        wait_n(3);
        chk({R1, R2}, 2'b00);
        dflt <= 1'b1;
        wait_n(3);
        chk({R1, R2, NO1, NC1, P2}, 5'b11101);
        dflt <= 1'b0;
        pfa <= 1'b0;
        pfb <= 1'b0;
        $display("test reset done");
    endtask
    // Codes that follow one input level each
    task set_in(input logic [4:0] c, input logic v);
        case (c)
            `OCS_C_RUN: run <= v;
            `OCS_C_COAST: bb <= v;
            `OCS_C_KEYPAD: kp <= v;
            `OCS_C_READY: rdy <= v;
            `OCS_C_TIMER: tin <= v;
            `OCS_C_RESTART: ars <= v;
            `OCS_C_OLWARN: mol <= v;
            `OCS_C_REFMISS: fmiss <= v;
            default: ser <= v;
        endcase
    endtask
    task t_direct;
        logic [4:0] cd [9] = '{`OCS_C_RUN, `OCS_C_COAST, `OCS_C_KEYPAD,
            `OCS_C_READY, `OCS_C_TIMER, `OCS_C_RESTART, `OCS_C_OLWARN,
            `OCS_C_REFMISS, `OCS_C_SERIAL};
        for (int i = 0; i < 9; i++) begin
            sel(cd[i], cd[i]);
            for (int v = 1; v >= 0; v--) begin
                set_in(cd[i], v[0]);
                wait_n(6);
                chk({R1, R2}, {v[0], v[0]});
            end
        end
        sel(5'h12, 5'h1F);
        run <= 1'b1;
        wait_n(3);
        chk({R1, R2}, 2'b00);
        run <= 1'b0;
        $display("test direct codes done");
    endtask
    task t_levels;
        sel(`OCS_C_OHWARN, `OCS_C_OLWARN);
        hs <= 8'd90;
        dol <= 8'd80;
        wait_n(3);
        chk({R1, R2}, 2'b11);
        hs <= 8'd89;
        dol <= 8'd79;
        wait_n(3);
        chk({R1, R2}, 2'b00);
        $display("test warning levels done");
    endtask
    task t_freq;
        wr(`OCS_REG_FREQ, 32'h00C8047E);
        sel(`OCS_C_FLOW, `OCS_C_FHIGH);
        fref <= 16'd1000;
        ofreq <= 16'd1150;
        wait_n(3);
        chk({R1, R2}, 2'b11);
        ofreq <= 16'd1149;
        wait_n(3);
        chk({R1, R2}, 2'b10);
        ofreq <= 16'd1151;
        wait_n(3);
        chk({R1, R2}, 2'b01);
        sel(`OCS_C_AGREE, `OCS_C_COINC);
        ofreq <= 16'd1150;
        wait_n(3);
        chk({R1, R2}, 2'b11);
        ofreq <= 16'd1300;
        wait_n(3);
        chk({R1, R2}, 2'b00);
        wr(`OCS_REG_FREQ, 32'h00C80BB8);
        ofreq <= 16'd1000;
        wait_n(3);
        chk({R1, R2}, 2'b10);
        $display("test frequency codes done");
    endtask
    task t_otq;
        logic [31:0] r;
        logic e;
        sel(`OCS_C_OTQ_NO, `OCS_C_OTQ_NC);
        otq(3'h2);
        cur <= 8'd100;
        wait_n(20);
        cur <= 8'd99;
        wait_n(2);
        cur <= 8'd100;
        wait_n(20);
        chk({OTI, R1, R2}, 3'b001);
        wait_n(40);
        chk({OTI, OTA, CST, R1, R2}, 5'b11010);
        cur <= 8'd99;
        wait_n(5);
        chk({OTI, R1, R2}, 3'b001);
        stp <= 1'b1;
        cur <= 8'd100;
        wait_n(60);
        chk(OTI, 1'b0);
        stp <= 1'b0;
        dcb <= 1'b1;
        wait_n(60);
        chk(OTI, 1'b0);
        dcb <= 1'b0;
        otq(3'h3);
        ofreq <= 16'd3000;
        wait_n(60);
        chk(OTI, 1'b0);
        otq(`OCS_OTQ_OFF);
        wait_n(60);
        chk(OTI, 1'b0);
        otq(3'h1);
        ofreq <= 16'd1000;
        wait_n(60);
        chk({OTI, OTA, CST}, 3'b110);
        otq(3'h4);
        wait_n(60);
        chk({OTI, OTA, CST}, 3'b101);
        cur <= 8'd0;
        apb(1'b0, `OCS_REG_STATUS, 32'h0, r, e);
        chk(r[`OCS_ST_OTQ_FAULT], 1'b1);
        wr(`OCS_REG_STATUS, 32'h1);
        wait_n(3);
        chk({OTI, CST}, 2'b00);
        $display("test overtorque done");
    endtask
    // Feedback below level must outlast the delay
    task t_fbloss;
        sel(`OCS_C_FBLOSS, `OCS_C_FBLOSS);
        wr(`OCS_REG_TIMER, {8'h02, 8'd50, 16'h0000});
        fb <= 8'd10;
        wait_n(12);
        chk({R1, R2}, 2'b00);
        wait_n(40);
        chk({R1, R2}, 2'b11);
        fb <= 8'd50;
        wait_n(3);
        chk({R1, R2}, 2'b00);
        $display("test feedback loss done");
    endtask
    // ----------------------------------------
    // Verdict, clock, watchdog, main sequence
    // ----------------------------------------
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #400000;
        err_total++;
        wrap_up;
    end
    initial begin
        {rst, psel, pen, pwr, paddr, pwdata} = {1'b1, 43'h0};
        {dflt, pfa, pfb, run, rdy, bb, kp, ars, ser, mol, fmiss} = 11'h0;
        {stp, dcb, tin, dol, hs, fb, cur, ofreq, fref} = 67'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_direct;
        t_levels;
        t_freq;
        t_fbloss;
        t_otq;
        wrap_up;
    end
endmodule // output_contact_select_overtorque_bench
`default_nettype wire
